// [pkg/mnx_pkg.sv]
// mnx_pkg: shared constants and types of the move/idle execute block
package mnx_pkg;

	// instruction word layout
	localparam int          INSN_W       = 14;
	localparam int          DATA_W       = 8;
	localparam int          FADDR_W      = 7;
	localparam int          LIT_LSB      = 0;
	localparam int          FADDR_LSB    = 0;
	localparam int          DEST_BIT     = 7;

	// opcode patterns: (word & mask) == pattern
	localparam logic [13:0] LOAD_MASK    = 14'h3C00;
	localparam logic [13:0] LOAD_PAT     = 14'h3000;
	localparam logic [13:0] COPY_MASK    = 14'h3F00;
	localparam logic [13:0] COPY_PAT     = 14'h0800;
	localparam logic [13:0] STORE_MASK   = 14'h3F80;
	localparam logic [13:0] STORE_PAT    = 14'h0080;
	localparam logic [13:0] IDLE_MASK    = 14'h3F9F;
	localparam logic [13:0] IDLE_PAT     = 14'h0000;

	// apb register map (byte addresses)
	localparam logic [7:0]  OFF_CTRL     = 8'h00;
	localparam logic [7:0]  OFF_STATUS   = 8'h04;
	localparam logic [7:0]  OFF_ACC      = 8'h08;
	localparam logic [7:0]  OFF_COUNT    = 8'h0C;
	localparam int          CTRL_RUN_BIT = 0;
	localparam int          STAT_Z_BIT   = 0;
	localparam int          STAT_CLS_LSB = 4;

	// reset values
	localparam logic        RUN_RST      = 1'b1;
	localparam logic [7:0]  ACC_RST      = 8'h00;
	localparam logic        ZERO_RST     = 1'b0;
	localparam logic [15:0] COUNT_RST    = 16'h0000;

	// quarter phases of one instruction cycle
	typedef enum logic [1:0] {
		QUARTER_PHASE_ONE   = 2'b00,
		QUARTER_PHASE_TWO   = 2'b01,
		QUARTER_PHASE_THREE = 2'b10,
		QUARTER_PHASE_FOUR  = 2'b11
	} mnx_qph_e;

	// instruction classes handled here
	typedef enum logic [2:0] {
		IDLE_INSTRUCTION            = 3'b000,
		LOAD_LITERAL_TO_ACCUMULATOR = 3'b001,
		COPY_FILE_REGISTER          = 3'b010,
		STORE_ACCUMULATOR_TO_FILE   = 3'b011,
		OTHER_INSTRUCTION           = 3'b100
	} mnx_insn_e;

	// file register request
	typedef struct packed {
		logic [6:0] addr;
		logic       rd_en;
		logic       wr_en;
		logic [7:0] wr_data;
	} mnx_fr_req_s;

endpackage

// [hw/mnx_quarter_seq.sv]
// mnx_quarter_seq: four quarter phase sequencer of the instruction cycle
`timescale 1ns/1ps
`default_nettype none
module mnx_quarter_seq (
	// clock, reset, freeze
	input  wire logic           clk_sys,
	input  wire logic           sys_rst,
	input  wire logic           clk_en,
	// current phase
	output var  mnx_pkg::mnx_qph_e ph_q
);
	mnx_pkg::mnx_qph_e ph_d;

	// advance one phase per enabled clock, wrap after the fourth
	always_comb
	begin
		ph_d = ph_q;
		if (clk_en)
		begin
			unique case (ph_q)
				mnx_pkg::QUARTER_PHASE_ONE:   ph_d = mnx_pkg::QUARTER_PHASE_TWO;
				mnx_pkg::QUARTER_PHASE_TWO:   ph_d = mnx_pkg::QUARTER_PHASE_THREE;
				mnx_pkg::QUARTER_PHASE_THREE: ph_d = mnx_pkg::QUARTER_PHASE_FOUR;
				mnx_pkg::QUARTER_PHASE_FOUR:  ph_d = mnx_pkg::QUARTER_PHASE_ONE;
			endcase
		end
	end

	// phase register
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			ph_q <= mnx_pkg::QUARTER_PHASE_ONE;
		else
			ph_q <= ph_d;
	end
endmodule
`default_nettype wire

// [hw/mnx_move_nop_exec.sv]
// mnx_move_nop_exec: literal load, file copy, accumulator store and idle execute
`timescale 1ns/1ps
`default_nettype none
module mnx_move_nop_exec (
	// clock, reset, freeze
	input  wire logic                 clk_sys,
	input  wire logic                 sys_rst,
	input  wire logic                 clk_en,
	// apb slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output var  logic [31:0]          prdata,
	output var  logic                 pready,
	output var  logic                 pslverr,
	// instruction fetch side
	input  wire logic [13:0]          instr_word,
	output var  mnx_pkg::mnx_qph_e    phase,
	// file register port
	output var  mnx_pkg::mnx_fr_req_s fr_req,
	input  wire logic [7:0]           fr_rd_data,
	// core state
	output var  logic [7:0]           acc,
	output var  logic                 zero_flag
);
	mnx_pkg::mnx_qph_e    ph_q;
	mnx_pkg::mnx_insn_e   dec_cls;
	mnx_pkg::mnx_insn_e   cls_q;
	mnx_pkg::mnx_insn_e   cls_d;
	mnx_pkg::mnx_fr_req_s fr_q;
	mnx_pkg::mnx_fr_req_s fr_d;
	logic [13:0]          ir_q;
	logic [13:0]          ir_d;
	logic [7:0]           result_q;
	logic [7:0]           result_d;
	logic [7:0]           acc_q;
	logic [7:0]           acc_d;
	logic                 zero_q;
	logic                 zero_d;
	logic [15:0]          count_q;
	logic [15:0]          count_d;
	logic                 run_q;
	logic                 run_d;
	logic [31:0]          prdata_q;
	logic [31:0]          prdata_d;
	logic                 pready_q;
	logic                 pready_d;
	logic                 pslverr_q;
	logic                 pslverr_d;
	logic                 apb_done;

	// phase sequencer
	mnx_quarter_seq u_seq (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.clk_en  (clk_en),
		.ph_q    (ph_q)
	);

	// outputs come straight from flops
	assign phase     = ph_q;
	assign fr_req    = fr_q;
	assign acc       = acc_q;
	assign zero_flag = zero_q;
	assign prdata    = prdata_q;
	assign pready    = pready_q;
	assign pslverr   = pslverr_q;

	// opcode classify; spare bits of literal load are masked out
	always_comb
	begin
		if ((instr_word & mnx_pkg::LOAD_MASK) == mnx_pkg::LOAD_PAT)
			dec_cls = mnx_pkg::LOAD_LITERAL_TO_ACCUMULATOR;
		else if ((instr_word & mnx_pkg::COPY_MASK) == mnx_pkg::COPY_PAT)
			dec_cls = mnx_pkg::COPY_FILE_REGISTER;
		else if ((instr_word & mnx_pkg::STORE_MASK) == mnx_pkg::STORE_PAT)
			dec_cls = mnx_pkg::STORE_ACCUMULATOR_TO_FILE;
		else if ((instr_word & mnx_pkg::IDLE_MASK) == mnx_pkg::IDLE_PAT)
			dec_cls = mnx_pkg::IDLE_INSTRUCTION;
		else
			dec_cls = mnx_pkg::OTHER_INSTRUCTION;
	end

	// execute next state; strobes last one phase only
	always_comb
	begin
		ir_d     = ir_q;
		cls_d    = cls_q;
		fr_d     = fr_q;
		result_d = result_q;
		acc_d    = acc_q;
		zero_d   = zero_q;
		count_d  = count_q;
		if (clk_en)
		begin
			fr_d.rd_en = 1'b0;
			fr_d.wr_en = 1'b0;
			unique case (ph_q)
				mnx_pkg::QUARTER_PHASE_ONE:
				begin
					// decode; a stopped core runs every word as idle
					ir_d       = instr_word;
					cls_d      = run_q ? dec_cls : mnx_pkg::IDLE_INSTRUCTION;
					fr_d.addr  = instr_word[mnx_pkg::FADDR_LSB +: mnx_pkg::FADDR_W];
					fr_d.rd_en = (cls_d == mnx_pkg::COPY_FILE_REGISTER);
				end
				mnx_pkg::QUARTER_PHASE_TWO:
				begin
					if (cls_q == mnx_pkg::LOAD_LITERAL_TO_ACCUMULATOR)
						result_d = ir_q[mnx_pkg::LIT_LSB +: mnx_pkg::DATA_W];
					else if (cls_q == mnx_pkg::STORE_ACCUMULATOR_TO_FILE)
						result_d = acc_q;
				end
				mnx_pkg::QUARTER_PHASE_THREE:
				begin
					// write strobe is raised here so it is high through phase four
					if (cls_q == mnx_pkg::COPY_FILE_REGISTER)
					begin
						result_d     = fr_rd_data;
						fr_d.wr_en   = ir_q[mnx_pkg::DEST_BIT];
						fr_d.wr_data = fr_rd_data;
					end
					else if (cls_q == mnx_pkg::STORE_ACCUMULATOR_TO_FILE)
					begin
						fr_d.wr_en   = 1'b1;
						fr_d.wr_data = result_q;
					end
				end
				mnx_pkg::QUARTER_PHASE_FOUR:
				begin
					count_d = count_q + 16'h0001;
					if (cls_q == mnx_pkg::LOAD_LITERAL_TO_ACCUMULATOR)
						acc_d = result_q;
					if (cls_q == mnx_pkg::COPY_FILE_REGISTER)
					begin
						if (!ir_q[mnx_pkg::DEST_BIT])
							acc_d = result_q;
						zero_d = (result_q == 8'h00);
					end
				end
			endcase
		end
	end

	// execute registers
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			ir_q     <= 14'h0000;
			cls_q    <= mnx_pkg::IDLE_INSTRUCTION;
			fr_q     <= '0;
			result_q <= 8'h00;
			acc_q    <= mnx_pkg::ACC_RST;
			zero_q   <= mnx_pkg::ZERO_RST;
			count_q  <= mnx_pkg::COUNT_RST;
		end
		else
		begin
			ir_q     <= ir_d;
			cls_q    <= cls_d;
			fr_q     <= fr_d;
			result_q <= result_d;
			acc_q    <= acc_d;
			zero_q   <= zero_d;
			count_q  <= count_d;
		end
	end

	// apb: one wait state; the access completes when pready is seen high
	assign apb_done = psel && penable && pready_q;

	always_comb
	begin
		pready_d  = pready_q;
		pslverr_d = pslverr_q;
		prdata_d  = prdata_q;
		run_d     = run_q;
		if (clk_en)
		begin
			pready_d  = psel && penable && !pready_q;
			pslverr_d = 1'b0;
			prdata_d  = '0;
			if (psel && penable && !pready_q)
			begin
				unique case (paddr)
					mnx_pkg::OFF_CTRL:   prdata_d[mnx_pkg::CTRL_RUN_BIT] = run_q;
					mnx_pkg::OFF_STATUS:
					begin
						prdata_d[mnx_pkg::STAT_Z_BIT]        = zero_q;
						prdata_d[mnx_pkg::STAT_CLS_LSB +: 3] = cls_q;
					end
					mnx_pkg::OFF_ACC:    prdata_d[7:0]  = acc_q;
					mnx_pkg::OFF_COUNT:  prdata_d[15:0] = count_q;
					default:             pslverr_d      = 1'b1;
				endcase
			end
			if (apb_done && pwrite && paddr == mnx_pkg::OFF_CTRL)
				run_d = pwdata[mnx_pkg::CTRL_RUN_BIT];
		end
	end

	// apb registers
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
			run_q     <= mnx_pkg::RUN_RST;
		end
		else
		begin
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q  <= prdata_d;
			run_q     <= run_d;
		end
	end

	// checks on the execute timing
	default clocking dcb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	load_acc_a: assert property (
		clk_en && ph_q == mnx_pkg::QUARTER_PHASE_FOUR && cls_q == mnx_pkg::LOAD_LITERAL_TO_ACCUMULATOR
		|=> acc_q == $past(ir_q[7:0]) && $stable(zero_q))
		else $error("literal load did not reach the accumulator");

	load_spare_a: assert property (
		clk_en && ph_q == mnx_pkg::QUARTER_PHASE_ONE && run_q && instr_word[13:10] == 4'hC
		|=> cls_q == mnx_pkg::LOAD_LITERAL_TO_ACCUMULATOR)
		else $error("spare bits changed literal load decode");

	acc_phase_a: assert property (
		!(clk_en && ph_q == mnx_pkg::QUARTER_PHASE_FOUR) |=> $stable(acc_q))
		else $error("accumulator changed outside phase four");

	copy_read_a: assert property (
		clk_en && ph_q == mnx_pkg::QUARTER_PHASE_ONE && run_q
		&& dec_cls == mnx_pkg::COPY_FILE_REGISTER
		|=> fr_q.rd_en && fr_q.addr == $past(instr_word[6:0]))
		else $error("file copy read not issued");

	copy_back_a: assert property (
		clk_en && ph_q == mnx_pkg::QUARTER_PHASE_THREE && cls_q == mnx_pkg::COPY_FILE_REGISTER
		&& ir_q[7]
		|=> fr_q.wr_en && fr_q.wr_data == $past(fr_rd_data) ##1 $stable(acc_q))
		else $error("file copy write back wrong");

	copy_zero_a: assert property (
		clk_en && ph_q == mnx_pkg::QUARTER_PHASE_FOUR && cls_q == mnx_pkg::COPY_FILE_REGISTER
		|=> zero_q == ($past(result_q) == 8'h00))
		else $error("zero flag not set from moved value");

	store_data_a: assert property (
		clk_en && ph_q == mnx_pkg::QUARTER_PHASE_THREE && cls_q == mnx_pkg::STORE_ACCUMULATOR_TO_FILE
		|=> fr_q.wr_en && fr_q.wr_data == acc_q ##1 $stable(zero_q))
		else $error("store wrote wrong data");

	write_phase_a: assert property (
		fr_q.wr_en |-> ph_q == mnx_pkg::QUARTER_PHASE_FOUR)
		else $error("file write outside phase four");

	idle_quiet_a: assert property (
		clk_en && ph_q != mnx_pkg::QUARTER_PHASE_ONE && cls_q == mnx_pkg::IDLE_INSTRUCTION
		|=> $stable(acc_q) && $stable(zero_q) && !fr_q.wr_en && !fr_q.rd_en)
		else $error("idle instruction changed state");

	load_cov_c:  cover property (clk_en && ph_q == mnx_pkg::QUARTER_PHASE_FOUR
		&& cls_q == mnx_pkg::LOAD_LITERAL_TO_ACCUMULATOR);
	copy_w_c:    cover property (clk_en && ph_q == mnx_pkg::QUARTER_PHASE_FOUR
		&& cls_q == mnx_pkg::COPY_FILE_REGISTER && !ir_q[7]);
	copy_f_c:    cover property (fr_q.wr_en && cls_q == mnx_pkg::COPY_FILE_REGISTER);
	store_cov_c: cover property (fr_q.wr_en && cls_q == mnx_pkg::STORE_ACCUMULATOR_TO_FILE);
	idle_cov_c:  cover property (clk_en && ph_q == mnx_pkg::QUARTER_PHASE_FOUR
		&& cls_q == mnx_pkg::IDLE_INSTRUCTION);
endmodule
`default_nettype wire

// [verification/mnx_file_mem.sv]
// mnx_file_mem: behavioural file register memory at the far side
`timescale 1ns/1ps
`default_nettype none
module mnx_file_mem (
	// clock and freeze
	input  wire logic                 clk_sys,
	input  wire logic                 clk_en,
	// file register port
	input  wire mnx_pkg::mnx_fr_req_s fr_req,
	output var  logic [7:0]           fr_rd_data
);
	logic [7:0] mem [128];

	// preload: every fourth byte zero so the zero flag sees both outcomes
	initial
	begin
		for (int i = 0; i < 128; i++)
			mem[i] = (i % 4 == 0) ? 8'h00 : 8'(i * 3);
		fr_rd_data = 8'h00;
	end

	// sync read held one phase; afterwards the byte is inverted so stale data never passes
	always @(posedge clk_sys)
		if (clk_en)
		begin
			fr_rd_data <= fr_req.rd_en ? mem[fr_req.addr] : ~fr_rd_data;
			if (fr_req.wr_en)
				mem[fr_req.addr] <= fr_req.wr_data;
		end
endmodule
`default_nettype wire

// [verification/testbench.sv]
// testbench: random and corner instruction stream with apb register checks
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic                 clk_sys = 1'b0, sys_rst = 1'b1, clk_en = 1'b1;
	logic                 psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]           paddr = 8'h00;
	logic [31:0]          pwdata = 32'h0000_0000, prdata;
	logic                 pready, pslverr, zero_flag, exp_z;
	logic [13:0]          instr_word = 14'h0000;
	mnx_pkg::mnx_qph_e    phase;
	mnx_pkg::mnx_fr_req_s fr_req;
	logic [7:0]           fr_rd_data, acc, exp_acc, shadow [128];
	int                   failures = 0, check_count = 0, cycles = 0, seed = 32'h703a_bbc6;

	mnx_move_nop_exec i_mnx_move_nop_exec (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.instr_word(instr_word), .phase(phase), .fr_req(fr_req), .fr_rd_data(fr_rd_data),
		.acc(acc), .zero_flag(zero_flag));
	mnx_file_mem i_mnx_file_mem (.clk_sys(clk_sys), .clk_en(clk_en), .fr_req(fr_req),
		.fr_rd_data(fr_rd_data));

	// 100 MHz clock
	initial
	begin
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic test_done;
		$display("checks %0d, mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// a stuck handshake ends the run here
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			failures++;
			test_done;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// entered at the edge that opens phase one; results show at the next call
	task automatic insn(input logic [13:0] w, input logic run);
		logic       rd;
		logic       wr;
		logic       wv;
		logic [7:0] wd;
		rd = run && (w & mnx_pkg::COPY_MASK) == mnx_pkg::COPY_PAT;
		wr = run && (w & mnx_pkg::STORE_MASK) == mnx_pkg::STORE_PAT;
		wv = wr || (rd && w[7]);
		wd = rd ? shadow[w[6:0]] : exp_acc;
		instr_word <= w;
		@(negedge clk_sys);
		chk(phase, mnx_pkg::QUARTER_PHASE_ONE, "phase");
		chk(acc, exp_acc, "acc");
		chk(zero_flag, exp_z, "zero flag");
		if (run && (w & mnx_pkg::LOAD_MASK) == mnx_pkg::LOAD_PAT)
			exp_acc = w[7:0];
		if (rd)
			exp_z = (wd == 8'h00);
		if (rd && !w[7])
			exp_acc = wd;
		if (wr)
			shadow[w[6:0]] = wd;
		@(negedge clk_sys);
		chk(fr_req.rd_en, rd, "read strobe");
		repeat (2) @(negedge clk_sys);
		chk(fr_req.wr_en, wv, "write strobe");
		if (rd || wr)
			chk(fr_req.addr, w[6:0], "address");
		if (wv)
			chk(fr_req.wr_data, wd, "write data");
		@(posedge clk_sys);
	endtask

	// apb master; the slave answers when it likes
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		// no wait limit here: only the bench timeout ends a wait that never sees pready
		do
			@(posedge clk_sys);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		instr_word <= 14'h0000;
		@(posedge clk_sys);
	endtask

	// wait for the edge that opens phase one
	task automatic align;
		do
			@(negedge clk_sys);
		while (phase !== mnx_pkg::QUARTER_PHASE_FOUR);
		@(posedge clk_sys);
	endtask

	// main sequence: corners, random stream, registers, halted run
	initial
	begin
		logic [31:0] r;
		logic [31:0] c;
		logic        e;
		logic [13:0] w;
		for (int i = 0; i < 128; i++)
			shadow[i] = (i % 4 == 0) ? 8'h00 : 8'(i * 3);
		exp_acc = 8'h00;
		exp_z = 1'b0;
		repeat (4) @(posedge clk_sys);
		sys_rst <= 1'b0;
		insn(14'h3000, 1'b1);
		insn(14'h33A5, 1'b1);
		insn(14'h0800, 1'b1);
		insn(14'h0881, 1'b1);
		insn(14'h00FF, 1'b1);
		insn(14'h0060, 1'b1);
		// a word of another class must raise no strobe and change nothing
		insn(14'h0485, 1'b1);
		// random operands, classes in turn so every kind runs back to back
		for (int k = 0; k < 300; k++)
		begin
			w = 14'($random(seed));
			case (k % 4)
				0: w = {6'h30, w[7:0]};
				1: w = {6'h08, w[7:0]};
				2: w = {7'h01, w[6:0]};
				default: w = w & 14'h0060;
			endcase
			insn(w, 1'b1);
		end
		apb(1'b0, mnx_pkg::OFF_CTRL, 32'h0000_0000, r, e);
		chk(r, 32'h0000_0001, "run bit");
		chk(e, 1'b0, "mapped error");
		// two reads four cycles apart straddle exactly one phase four
		apb(1'b0, mnx_pkg::OFF_COUNT, 32'h0000_0000, c, e);
		apb(1'b0, mnx_pkg::OFF_COUNT, 32'h0000_0000, r, e);
		chk(r, c + 32'h0000_0001, "count step");
		apb(1'b0, mnx_pkg::OFF_ACC, 32'h0000_0000, r, e);
		chk(r, {24'h00_0000, exp_acc}, "acc register");
		apb(1'b0, mnx_pkg::OFF_STATUS, 32'h0000_0000, r, e);
		chk(r[0], exp_z, "status zero");
		apb(1'b0, 8'h10, 32'h0000_0000, r, e);
		chk(r, 32'h0000_0000, "unmapped data");
		chk(e, 1'b1, "unmapped error");
		// halted core runs every word as idle
		apb(1'b1, mnx_pkg::OFF_CTRL, 32'h0000_0000, r, e);
		align;
		insn(14'h30C3, 1'b0);
		insn(14'h0885, 1'b0);
		apb(1'b1, mnx_pkg::OFF_CTRL, 32'h0000_0001, r, e);
		align;
		// a low enable freezes every flop; the load then runs late
		clk_en <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk(phase, mnx_pkg::QUARTER_PHASE_ONE, "frozen phase");
		chk(acc, exp_acc, "frozen acc");
		clk_en <= 1'b1;
		insn(14'h3077, 1'b1);
		insn(14'h0801, 1'b1);
		insn(14'h0000, 1'b1);
		// mid-run reset while halted must bring back the reset values
		apb(1'b1, mnx_pkg::OFF_CTRL, 32'h0000_0000, r, e);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		exp_acc = 8'h00;
		exp_z = 1'b0;
		apb(1'b0, mnx_pkg::OFF_CTRL, 32'h0000_0000, r, e);
		chk(r, 32'h0000_0001, "run after reset");
		insn(14'h0805, 1'b1);
		apb(1'b0, mnx_pkg::OFF_ACC, 32'h0000_0000, r, e);
		chk(r, {24'h00_0000, exp_acc}, "acc after copy");
		apb(1'b0, mnx_pkg::OFF_STATUS, 32'h0000_0000, r, e);
		chk(r[0], exp_z, "zero after copy");
		test_done;
	end
endmodule
`default_nettype wire
